/* hdl/gfs_cfg.svh */
/*
  Constants for the global fault status register: offsets, bit positions,
  reset values and default counts.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef GFS_CFG_SVH
`define GFS_CFG_SVH

`define GFS_ADDR_GLOBAL_STATUS 6'h01
`define GFS_ADDR_MOTOR_STATUS 6'h02
`define GFS_RESET_VAL 16'h0000
`define GFS_BIT_BAT_OV 15
`define GFS_BIT_BAT_UV 14
`define GFS_BIT_REG_OV 13
`define GFS_BIT_REG_UVW 12
`define GFS_BIT_RSVD_HI 11
`define GFS_BIT_CP_FAIL 10
`define GFS_BIT_V5_UVW 9
`define GFS_BIT_V5_OV 8
`define GFS_BIT_V5_UV 7
`define GFS_BIT_THERM_WARN 6
`define GFS_BIT_THERM_SD 5
`define GFS_BIT_OPEN_LOAD 4
`define GFS_BIT_OVERCURRENT 3
`define GFS_BIT_STALL 2
`define GFS_BIT_RSVD_LO 1
`define GFS_BIT_PARITY 0
`define GFS_MSR_OC_HI 15
`define GFS_MSR_OC_LO 8
`define GFS_MSR_OL_A 7
`define GFS_MSR_OL_B 6
`define GFS_FRAME_BITS 24
`define GFS_OL_DELAY_BITS 16
`define GFS_COIL_BITS 10
`define GFS_STALL_CNT_BITS 3

`endif

/* hdl/gfs_parity.sv */
/*
  Odd parity over a frame: the returned bit makes the total count of ones odd.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps

module gfs_parity #(
  parameter int WIDTH = 23
) (
  input wire logic [WIDTH-1:0] bits_i, // Frame bits without the parity bit.
  output logic parity_o // Odd parity bit.
);
  import gfs_pkg::*;

  initial begin
    if (WIDTH < 1) begin
      $error("gfs_parity: WIDTH must be at least 1");
    end
  end

  assign parity_o = ~(^bits_i);

endmodule : gfs_parity

/* hdl/gfs_pkg.sv */
/*
  Types shared by the global fault status logic.
  Assumes gfs_cfg.svh is on the include path.
*/
`include "gfs_cfg.svh"

package gfs_pkg;

  // Level conditions from the analog monitors.
  typedef struct packed {
    logic battery_supply_overvoltage;
    logic battery_supply_undervoltage;
    logic internal_regulator_overvoltage;
    logic internal_regulator_undervoltage_warning;
    logic charge_pump_failure;
    logic five_volt_undervoltage_warning;
    logic five_volt_overvoltage;
    logic five_volt_undervoltage;
    logic thermal_warning;
    logic thermal_shutdown;
  } gfs_monitor_type;

  // One coil voltage acquisition and its window settings.
  typedef struct packed {
    logic coil_voltage_measure_enable;
    logic acq_valid;
    logic [`GFS_COIL_BITS-1:0] sample;
    logic [`GFS_COIL_BITS-1:0] coil_voltage_lower_limit_a;
    logic [`GFS_COIL_BITS-1:0] coil_voltage_upper_limit;
    logic [`GFS_STALL_CNT_BITS-1:0] stall_count_limit;
  } gfs_coil_type;

  typedef enum logic [1:0] {
    GFS_OL_IDLE = 2'h0,
    GFS_OL_WAIT = 2'h1,
    GFS_OL_DONE = 2'h3
  } gfs_ol_state_type;

endpackage : gfs_pkg

/* hdl/gfs_stall_detect.sv */
/*
  Counts consecutive out-of-window coil voltage acquisitions and pulses on
  each such acquisition from the programmed count onward.
  Assumes acq_valid is a one-cycle pulse per zero-current step.
*/
`timescale 1ns/1ps
`include "gfs_cfg.svh"

module gfs_stall_detect #(
  parameter int CNT_W = `GFS_STALL_CNT_BITS
) (
  input wire logic clk_sys_i, // System clock.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire gfs_pkg::gfs_coil_type coil_i, // Acquisition and settings.
  output logic stall_evt_o // One-cycle stall event.
);
  import gfs_pkg::*;

  initial begin
    if (CNT_W != `GFS_STALL_CNT_BITS) begin
      $error("gfs_stall_detect: CNT_W must match the stall count field");
    end
  end

  logic [CNT_W-1:0] run_r;
  logic [CNT_W-1:0] run_nxt;
  logic hit_r;
  logic hit_nxt;
  logic out_of_range;
  logic limit_met;
  logic sample_en;
  logic [CNT_W:0] run_inc;

  // Outside the window between lower limit A and the upper limit.
  assign out_of_range = (coil_i.sample < coil_i.coil_voltage_lower_limit_a) ||
                        (coil_i.sample > coil_i.coil_voltage_upper_limit);
  assign sample_en = coil_i.acq_valid && coil_i.coil_voltage_measure_enable;
  // A limit of zero flags on the first out-of-range acquisition.
  // One extra bit keeps a saturated run from wrapping to zero.
  assign run_inc = {1'b0, run_r} + {{CNT_W{1'b0}}, 1'b1};
  assign limit_met = (run_inc >= {1'b0, coil_i.stall_count_limit}) ||
                     (coil_i.stall_count_limit == '0);
  assign run_nxt = !coil_i.coil_voltage_measure_enable ? '0 :
                   !coil_i.acq_valid ? run_r :
                   !out_of_range ? '0 :
                   (run_r == {CNT_W{1'b1}}) ? run_r : run_r + 1'b1;
  assign hit_nxt = sample_en && out_of_range && limit_met;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_r <= '0;
      hit_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign stall_evt_o = hit_r;

endmodule : gfs_stall_detect

/* hdl/gfs_top.sv */
/*
  Global fault status register of a stepper motor driver, with the open-load
  and overcurrent flags of the motor status register that it summarises.
  Assumes the serial frame logic outside decodes a read or a read-and-clear
  access into one-cycle strobes, and that monitor inputs are synchronous.
*/
// Behaviour
// - Supply faults latch at bits 15, 14; regulator faults at 13, 12.
// - Charge pump failure latches at bit 10.
// - Five-volt regulator: warning bit 9, overvoltage bit 8, undervoltage bit 7.
// - Thermal warning latches at bit 6, thermal shutdown at bit 5.
// - Open-load summary bit 4 sets when either phase open-load flag sets.
// - Clearing open-load summary also clears both phase open-load flags.
// - Overcurrent summary bit 3 sets when any of eight switch flags sets.
// - Clearing overcurrent summary also clears all eight switch flags.
// - Stall counts only with measurement enabled and voltage outside the window.
// - Stall bit 2 sets after the programmed count of consecutive acquisitions.
// - Bit 0 carries odd parity over the whole serial frame.
// - Phase open-load sets when reference current is missed within the delay.
`timescale 1ns/1ps
`include "gfs_cfg.svh"

module gfs_top #(
  parameter int FRAME_W = `GFS_FRAME_BITS,
  parameter int OL_DLY_W = `GFS_OL_DELAY_BITS
) (
  input wire logic clk_sys_i, // System clock, 200 MHz.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire gfs_pkg::gfs_monitor_type monitor_i, // Monitor fault levels.
  input wire logic [7:0] oc_detect_i, // Per-switch overcurrent detect.
  input wire logic [1:0] phase_start_i, // New current reference, phase A bit 1.
  input wire logic [1:0] cur_reached_i, // Reference current reached per phase.
  input wire logic [OL_DLY_W-1:0] ol_delay_i, // Open-load delay in cycles.
  input wire gfs_pkg::gfs_coil_type coil_i, // Coil voltage acquisition.
  input wire logic rd_i, // Read strobe from the frame logic.
  input wire logic clr_i, // Read-and-clear strobe from the frame logic.
  input wire logic [5:0] addr_i, // Register address of the access.
  input wire logic [15:0] clr_mask_i, // Bits to clear, one per flag.
  input wire logic [FRAME_W-17:0] frame_rest_i, // Other frame bits for parity.
  output logic [15:0] rd_data_o, // Read word with parity in bit 0.
  output logic rd_valid_o, // Read word valid, one cycle.
  output logic [15:0] global_fault_status_o, // Live flag word, parity bit zero.
  output logic [7:0] oc_flags_o, // Per-switch overcurrent flags.
  output logic [1:0] ol_flags_o // Phase A bit 1, phase B bit 0.
);
  import gfs_pkg::*;

  initial begin
    if (FRAME_W < 17) begin
      $error("gfs_top: FRAME_W must hold the 16-bit payload plus one bit");
    end
    if (OL_DLY_W < 1) begin
      $error("gfs_top: OL_DLY_W must be at least 1");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode.

  logic hit_gsr;
  logic hit_msr;
  logic access;
  logic [15:0] gsr_clr;

  assign access = rd_i || clr_i;
  assign hit_gsr = addr_i == `GFS_ADDR_GLOBAL_STATUS;
  assign hit_msr = addr_i == `GFS_ADDR_MOTOR_STATUS;
  assign gsr_clr = (clr_i && hit_gsr) ? clr_mask_i : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase open-load timers.

  logic [1:0] ol_evt;

  for (genvar ph = 0; ph < 2; ph++) begin : g_ol
    gfs_ol_state_type st_r;
    gfs_ol_state_type st_nxt;
    logic [OL_DLY_W-1:0] cnt_r;
    logic [OL_DLY_W-1:0] cnt_nxt;
    logic timeout;
    logic evt_r;

    assign timeout = (st_r == GFS_OL_WAIT) && !cur_reached_i[ph] && (cnt_r == '0);

    always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      if (phase_start_i[ph]) begin
        st_nxt = GFS_OL_WAIT;
        cnt_nxt = ol_delay_i;
      end else begin
        unique case (st_r)
          GFS_OL_IDLE: begin
            st_nxt = GFS_OL_IDLE;
          end
          GFS_OL_WAIT: begin
            if (cur_reached_i[ph] || timeout) begin
              st_nxt = GFS_OL_DONE;
            end else begin
              cnt_nxt = cnt_r - 1'b1;
            end
          end
          GFS_OL_DONE: begin
            st_nxt = GFS_OL_DONE;
          end
          default: begin
            st_nxt = GFS_OL_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        st_r <= GFS_OL_IDLE;
        cnt_r <= '0;
        evt_r <= 1'b0;
      end else begin
        st_r <= st_nxt;
        cnt_r <= cnt_nxt;
        evt_r <= timeout && !phase_start_i[ph];
      end
    end

    assign ol_evt[ph] = evt_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stall detection and parity.

  logic stall_evt;
  logic rd_parity;
  logic [15:0] rd_word;

  gfs_stall_detect #(
    .CNT_W(`GFS_STALL_CNT_BITS)
  ) gfs_stall_detect_i (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .coil_i(coil_i),
    .stall_evt_o(stall_evt)
  );

  gfs_parity #(
    .WIDTH(FRAME_W - 1)
  ) gfs_parity_i (
    .bits_i({frame_rest_i, rd_word[15:1]}),
    .parity_o(rd_parity)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Motor status flags summarised here.

  logic [7:0] oc_r;
  logic [7:0] oc_nxt;
  logic [1:0] ol_r;
  logic [1:0] ol_nxt;
  logic oc_sum_clr;
  logic ol_sum_clr;

  assign oc_sum_clr = gsr_clr[`GFS_BIT_OVERCURRENT];
  assign ol_sum_clr = gsr_clr[`GFS_BIT_OPEN_LOAD];
  // A new detection in the clearing cycle survives the clear.
  assign oc_nxt = (oc_r & ~{8{oc_sum_clr}}) | oc_detect_i;
  assign ol_nxt = (ol_r & ~{2{ol_sum_clr}}) | ol_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Global flag word.

  logic [15:0] gsr_r;
  logic [15:0] gsr_nxt;
  logic [15:0] gsr_set;
  logic [15:0] gsr_impl;

  always_comb begin
    gsr_set = 16'h0000;
    gsr_set[`GFS_BIT_BAT_OV] = monitor_i.battery_supply_overvoltage;
    gsr_set[`GFS_BIT_BAT_UV] = monitor_i.battery_supply_undervoltage;
    gsr_set[`GFS_BIT_REG_OV] = monitor_i.internal_regulator_overvoltage;
    gsr_set[`GFS_BIT_REG_UVW] = monitor_i.internal_regulator_undervoltage_warning;
    gsr_set[`GFS_BIT_CP_FAIL] = monitor_i.charge_pump_failure;
    gsr_set[`GFS_BIT_V5_UVW] = monitor_i.five_volt_undervoltage_warning;
    gsr_set[`GFS_BIT_V5_OV] = monitor_i.five_volt_overvoltage;
    gsr_set[`GFS_BIT_V5_UV] = monitor_i.five_volt_undervoltage;
    gsr_set[`GFS_BIT_THERM_WARN] = monitor_i.thermal_warning;
    gsr_set[`GFS_BIT_THERM_SD] = monitor_i.thermal_shutdown;
    gsr_set[`GFS_BIT_OPEN_LOAD] = |ol_nxt;
    gsr_set[`GFS_BIT_OVERCURRENT] = |oc_nxt;
    gsr_set[`GFS_BIT_STALL] = stall_evt;
  end

  // Reserved and parity positions never hold state.
  always_comb begin
    gsr_impl = 16'hFFFF;
    gsr_impl[`GFS_BIT_RSVD_HI] = 1'b0;
    gsr_impl[`GFS_BIT_RSVD_LO] = 1'b0;
    gsr_impl[`GFS_BIT_PARITY] = 1'b0;
  end

  // Set wins over clear; a flag drops only on a host clear.
  assign gsr_nxt = ((gsr_r & ~gsr_clr) | gsr_set) & gsr_impl;

  ////////////////////////////////////////////////////////////////////////////
  // Read path: the word is the value before any clear of the same access.

  logic [15:0] msr_word;

  always_comb begin
    msr_word = 16'h0000;
    msr_word[`GFS_MSR_OC_HI:`GFS_MSR_OC_LO] = oc_r;
    msr_word[`GFS_MSR_OL_A] = ol_r[1];
    msr_word[`GFS_MSR_OL_B] = ol_r[0];
  end

  assign rd_word = hit_gsr ? gsr_r : (hit_msr ? msr_word : 16'h0000);

  logic [15:0] rd_data_r;
  logic rd_valid_r;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gsr_r <= `GFS_RESET_VAL;
      oc_r <= 8'h00;
      ol_r <= 2'h0;
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      gsr_r <= gsr_nxt;
      oc_r <= oc_nxt;
      ol_r <= ol_nxt;
      rd_valid_r <= access;
      if (access) begin
        rd_data_r <= {rd_word[15:1], rd_parity};
      end
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign global_fault_status_o = gsr_r;
  assign oc_flags_o = oc_r;
  assign ol_flags_o = ol_r;

endmodule : gfs_top

/* tb/gfs_checker.sv */
/* Assertions on the ports of gfs_top.
   Bound to gfs_top from the bench top file. */
`timescale 1ns/1ps
module gfs_checker #(parameter int FRAME_W = 24) (
  input wire logic clk_sys_i, // Clock.
  input wire logic nrst_i, // Reset.
  input wire gfs_pkg::gfs_monitor_type monitor_i, // Monitors.
  input wire logic [7:0] oc_detect_i, // Switch detect.
  input wire gfs_pkg::gfs_coil_type coil_i, // Coil.
  input wire logic rd_i, // Read.
  input wire logic clr_i, // Clear.
  input wire logic [5:0] addr_i, // Address.
  input wire logic [15:0] clr_mask_i, // Mask.
  input wire logic [FRAME_W-17:0] frame_rest_i, // Frame bits.
  input wire logic [15:0] rd_data_o, // Read word.
  input wire logic rd_valid_o, // Valid.
  input wire logic [15:0] global_fault_status_o, // Flags.
  input wire logic [7:0] oc_flags_o, // Switch flags.
  input wire logic [1:0] ol_flags_o // Phase flags.
);
  import gfs_pkg::*;
  wire logic [15:0] g = global_fault_status_o;
  wire logic acc = rd_i | clr_i;
  wire logic [9:0] mw = {g[15:12], g[10:5]};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_answer_one: assert property (acc |=> rd_valid_o) else $error("no answer");
  a_answer_once: assert property (!acc |=> !rd_valid_o) else $error("stray valid");
  a_parity_odd: assert property (acc |=> ^{$past(frame_rest_i), rd_data_o})
    else $error("parity even");
  a_monitor_set: assert property (1 |=> (mw & $past(monitor_i)) == $past(monitor_i))
    else $error("monitor flag lost");
  a_oc_capture: assert property (1 |=> (oc_flags_o & $past(oc_detect_i)) == $past(oc_detect_i))
    else $error("switch flag lost");
  a_oc_summary: assert property (g[3] == |oc_flags_o) else $error("oc summary");
  a_ol_summary: assert property (g[4] == |ol_flags_o) else $error("ol summary");
  a_flag_sticky: assert property (!clr_i |=> (g & $past(g)) == $past(g))
    else $error("flag dropped");
  a_clear_works: assert property (clr_i && addr_i == 6'h01 && monitor_i == 0 |=>
    ((g & $past(clr_mask_i)) & 16'hFFE0) == 16'h0000) else $error("clear failed");
  a_rsvd_zero: assert property (g[11] == 1'b0 && g[1:0] == 2'h0) else $error("reserved set");
  a_read_word: assert property (acc && addr_i == 6'h01 |=> {rd_data_o[15:1], 1'b0} == $past(g))
    else $error("read word");
  a_stall_gate: assert property ($rose(g[2]) |-> $past(coil_i.acq_valid, 2) &&
    $past(coil_i.coil_voltage_measure_enable, 2)) else $error("stall ungated");
endmodule : gfs_checker

/* tb/gfs_host_model.sv */
/* Host side of the register link: read or read-and-clear strobes.
   Assumes a one-cycle answer the cycle after the access. */
`timescale 1ns/1ps
module gfs_host_model (
  input wire logic clk_sys_i, // Clock.
  input wire logic rd_valid_i, // Answer valid.
  input wire logic [15:0] rd_data_i, // Answer word.
  output logic rd_o, // Read.
  output logic clr_o, // Clear.
  output logic [5:0] addr_o, // Address.
  output logic [15:0] mask_o, // Mask.
  output logic [7:0] rest_o // Frame bits.
);
  import gfs_pkg::*;
  initial begin
    rd_o = 1'b0;
    clr_o = 1'b0;
    addr_o = 6'h00;
    mask_o = 16'h0000;
    rest_o = 8'h00;
  end
  // Released address, mask and frame lines show the inverse so a stale value is never mistaken for a live one.
  task automatic acc(input logic c, input logic [5:0] a, input logic [15:0] m,
    input logic [7:0] r, output logic [15:0] d);
    @(posedge clk_sys_i);
    rd_o <= !c;
    clr_o <= c;
    addr_o <= a;
    mask_o <= m;
    rest_o <= r;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    clr_o <= 1'b0;
    addr_o <= ~a;
    mask_o <= ~m;
    rest_o <= ~r;
    #1;
    d = rd_valid_i ? rd_data_i : 16'hXXXX;
  endtask : acc
endmodule : gfs_host_model

/* tb/global_fault_status_register_tb.sv */
/* Self-checking bench for gfs_top with a host model and a checker.
   Assumes the design files and gfs_cfg.svh are compiled first. */
`timescale 1ns/1ps
module global_fault_status_register_tb;
  import gfs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  gfs_monitor_type mon = '0;
  logic [7:0] oc = 8'h00;
  logic [1:0] ps = 2'h0;
  logic [1:0] cr = 2'h0;
  logic [15:0] dly = 16'h0003;
  gfs_coil_type coil = '0;
  logic rd, clr, rv;
  logic [5:0] addr;
  logic [15:0] mask, rdat, gfs;
  logic [7:0] rest, ocf;
  logic [1:0] olf;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  gfs_top gfs_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .monitor_i(mon), .oc_detect_i(oc),
    .phase_start_i(ps), .cur_reached_i(cr), .ol_delay_i(dly), .coil_i(coil), .rd_i(rd),
    .clr_i(clr), .addr_i(addr), .clr_mask_i(mask), .frame_rest_i(rest), .rd_data_o(rdat),
    .rd_valid_o(rv), .global_fault_status_o(gfs), .oc_flags_o(ocf), .ol_flags_o(olf));
  gfs_host_model gfs_host_model_i (.clk_sys_i(clk_sys_i), .rd_valid_i(rv), .rd_data_i(rdat),
    .rd_o(rd), .clr_o(clr), .addr_o(addr), .mask_o(mask), .rest_o(rest));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] xw(input logic [15:0] w, input logic [7:0] r);
    return {w[15:1], ~^{r, w[15:1]}};
  endfunction : xw
  function automatic logic [15:0] m2w(input logic [9:0] m);
    return {m[9:6], 1'b0, m[5:0], 5'h00};
  endfunction : m2w
  function automatic logic [9:0] out_of_window();
    return $urandom_range(0, 1) ? 10'($urandom_range(0, 99)) : 10'($urandom_range(201, 1023));
  endfunction : out_of_window
  task automatic rdx(input logic c, input logic [5:0] a, input logic [15:0] m,
    input logic [15:0] e);
    logic [7:0] r;
    logic [15:0] d;
    r = 8'($urandom);
    gfs_host_model_i.acc(c, a, m, r, d);
    chk(d, xw(e, r));
  endtask : rdx
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic pulse(input gfs_monitor_type m, input logic [7:0] o, input logic [1:0] p,
    input logic [1:0] c);
    @(posedge clk_sys_i);
    mon <= m;
    oc <= o;
    ps <= p;
    cr <= c;
    @(posedge clk_sys_i);
    mon <= '0;
    oc <= 8'h00;
    ps <= 2'h0;
  endtask : pulse
  task automatic acq(input logic en, input logic [2:0] lim, input logic [9:0] s);
    @(posedge clk_sys_i);
    coil <= {en, 1'b1, s, 10'h064, 10'h0C8, lim};
    @(posedge clk_sys_i);
    coil.acq_valid <= 1'b0;
  endtask : acq
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int v;
    int lim;
    v = $urandom(32'hF4BE5814);
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    tick(1);
    chk(gfs, 16'h0000);
    rdx(0, 6'h01, 16'h0000, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      pulse(10'(1 << i), 8'h00, 2'h0, 2'h0);
      rdx(1, 6'h01, 16'hFFFF, m2w(10'(1 << i)));
    end
    repeat (20) begin
      v = $urandom;
      pulse(v[9:0], 8'h00, 2'h0, 2'h0);
      rdx(0, 6'h01, 16'h0000, m2w(v[9:0]));
      rdx(1, 6'h01, 16'hFFFF, m2w(v[9:0]));
    end
    pulse(10'h3FF, 8'h00, 2'h0, 2'h0);
    rdx(0, 6'h05, 16'h0000, 16'h0000);
    rdx(1, 6'h01, 16'h00FF, 16'hF7E0);
    rdx(1, 6'h01, 16'hFFFF, 16'hF700);
    $display("test monitors done");
    v = $urandom_range(1, 255);
    pulse('0, v[7:0], 2'h0, 2'h0);
    tick(1);
    chk({8'h00, ocf}, {8'h00, v[7:0]});
    chk(16'(gfs[3]), 16'h0001);
    rdx(1, 6'h02, 16'hFFFF, {v[7:0], 8'h00});
    rdx(1, 6'h01, 16'h0008, 16'h0008);
    tick(1);
    chk({8'h00, ocf}, 16'h0000);
    $display("test overcurrent done");
    pulse('0, 8'h00, 2'b10, 2'b00);
    tick(9);
    chk({14'h0, olf}, 16'h0002);
    chk(16'(gfs[4]), 16'h0001);
    rdx(1, 6'h01, 16'h0010, 16'h0010);
    tick(1);
    chk({14'h0, olf}, 16'h0000);
    pulse('0, 8'h00, 2'b01, 2'b01);
    tick(9);
    chk({14'h0, olf}, 16'h0000);
    $display("test open load done");
    lim = $urandom_range(2, 7);
    repeat (lim - 1) acq(1'b1, lim[2:0], out_of_window());
    acq(1'b1, lim[2:0], 10'h064);
    repeat (lim - 1) acq(1'b1, lim[2:0], out_of_window());
    tick(3);
    chk(16'(gfs[2]), 16'h0000);
    acq(1'b1, lim[2:0], out_of_window());
    tick(3);
    chk(16'(gfs[2]), 16'h0001);
    rdx(1, 6'h01, 16'h0004, 16'h0004);
    repeat (lim + 1) acq(1'b0, lim[2:0], out_of_window());
    tick(3);
    chk(16'(gfs[2]), 16'h0000);
    $display("test stall done");
    close_out();
  end
endmodule : global_fault_status_register_tb

bind gfs_top gfs_checker #(.FRAME_W(FRAME_W)) gfs_checker_i (.*);
